// file: core/ts_access_pkg.sv
// constants for the two-wire register access target
package ts_access_pkg;
	localparam int unsigned CLK_HZ         = 50_000_000;
	localparam int unsigned TIMEOUT_MIN_MS = 25;
	localparam int unsigned TIMEOUT_MAX_MS = 35;
	localparam int unsigned TIMEOUT_MS     = 30;
	localparam int unsigned TIMEOUT_CYC    = CLK_HZ / 1000 * TIMEOUT_MS;
	localparam int unsigned SCL_MIN_KHZ    = 10;
	localparam int unsigned SCL_MAX_KHZ    = 1000;
	localparam logic [6:0]  DEV_ADDR_RST   = 7'h18;
	localparam logic [7:0]  POINTER_RST    = 8'h00;
	localparam int unsigned BIT_CNT_W      = 4;
	localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
endpackage

// file: core/ts_line_edges.sv
// start, stop and clock edge detection on the serial lines
`timescale 1ns/1ns
`default_nettype none
module ts_line_edges
	import ts_access_pkg::*;
(
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      start_seen,
	output logic      stop_seen,
	output logic      scl_level,
	output logic      sda_level
);
	logic scl_q;
	logic sda_q;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	assign scl_rise   = scl & ~scl_q;
	assign scl_fall   = ~scl & scl_q;
	// sda moving while scl stays high marks framing
	assign start_seen = scl & scl_q & sda_q & ~sda;
	assign stop_seen  = scl & scl_q & ~sda_q & sda;
	assign scl_level  = scl_q;
	assign sda_level  = sda_q;
endmodule
`default_nettype wire

// file: core/ts_reg_access.sv
// two-wire target giving pointer-based access to 16-bit registers
// What this block does
// - A write is address byte, pointer byte, then two data bytes making one 16-bit value.
// - The last pointer loaded is kept so reads without a pointer byte use it.
// - On a matching read address the target acknowledges and sends the high byte first.
// - After the master acknowledges the high byte the target sends the low byte.
// - Address and pointer bytes are acknowledged, then a repeated Start follows.
// - After the repeated Start the read address is acknowledged and the word sent high first.
// - A pointer from a preset read is kept for later latched-pointer reads too.
// - A bus timeout of 25 to 35 ms abandons a stalled transaction.
`timescale 1ns/1ns
`default_nettype none
module ts_reg_access
	import ts_access_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [6:0]  dev_addr,
	input  wire logic        scl,
	input  wire logic        sda,
	output logic             sda_val,
	output logic             sda_oe,
	output logic [7:0]       reg_index,
	input  wire logic [15:0] reg_rdata,
	output logic [15:0]      reg_wdata,
	output logic             reg_we,
	output logic             bus_timeout
);
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_PTR  = 7'h04,
		ST_WHI  = 7'h08,
		ST_WLO  = 7'h10,
		ST_RD   = 7'h20,
		ST_DONE = 7'h40
	} state_e;

	state_e          state_q, state_d;
	logic [7:0]      shift_q;
	logic [3:0]      bit_q;
	logic            ack_phase_q;
	logic            rd_lo_q;
	logic            tgt_ack_q;
	logic [7:0]      ptr_q;
	logic [7:0]      wr_hi_q;
	logic [15:0]     wdata_q;
	logic            we_q;
	logic            drive_q;
	logic [7:0]      tx_q;
	logic [31:0]     idle_cnt_q;
	logic            tout_q;

	logic scl_rise, scl_fall, start_seen, stop_seen, scl_level, sda_level;

	ts_line_edges u_edges (
		.mclk       (mclk),
		.reset      (reset),
		.scl        (scl),
		.sda        (sda),
		.scl_rise   (scl_rise),
		.scl_fall   (scl_fall),
		.start_seen (start_seen),
		.stop_seen  (stop_seen),
		.scl_level  (scl_level),
		.sda_level  (sda_level)
	);

	wire       active     = (state_q != ST_IDLE) && (state_q != ST_DONE);
	wire       byte_done  = scl_rise && !ack_phase_q && (bit_q == BITS_PER_BYTE - 4'h1);
	wire       byte_full  = (bit_q == BITS_PER_BYTE);
	wire [7:0] rx_byte    = {shift_q[6:0], sda_level};
	wire       addr_match = (rx_byte[7:1] == dev_addr);
	wire       rd_sel     = rx_byte[0];
	wire       tout_hit   = active && (idle_cnt_q >= TIMEOUT_CYCLES - 1);
	wire       in_read    = (state_q == ST_RD);
	// accepted bytes: matching address, pointer and both data bytes
	wire       ack_due    = (state_q == ST_ADDR && addr_match) || (state_q == ST_PTR) ||
		(state_q == ST_WHI) || (state_q == ST_WLO);
	// in reads the master owns the ack slot after each data byte
	wire       master_ack_slot = in_read && ack_phase_q && !tgt_ack_q;

	always_comb begin
		state_d = state_q;
		if (start_seen) begin
			state_d = ST_ADDR;
		end else if (stop_seen || tout_hit) begin
			state_d = ST_IDLE;
		end else if (byte_done) begin
			unique case (state_q)
				ST_ADDR: state_d = !addr_match ? ST_DONE :
					(rd_sel ? ST_RD : ST_PTR);
				ST_PTR:  state_d = ST_WHI;
				ST_WHI:  state_d = ST_WLO;
				ST_WLO:  state_d = ST_DONE;
				default: state_d = state_q;
			endcase
		end else if (master_ack_slot && scl_rise && sda_level) begin
			state_d = ST_DONE;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// bit counter, ack slot and receive shift
	// ack slot spans the fall after the eighth rise to the fall after the ninth
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bit_q       <= 4'h0;
			ack_phase_q <= 1'b0;
			shift_q     <= 8'h00;
		end else if (start_seen || state_d == ST_IDLE) begin
			bit_q       <= 4'h0;
			ack_phase_q <= 1'b0;
		end else if (scl_fall && ack_phase_q) begin
			ack_phase_q <= 1'b0;
			bit_q       <= 4'h0;
		end else if (scl_fall && byte_full) begin
			ack_phase_q <= 1'b1;
		end else if (scl_rise && !ack_phase_q && !byte_full) begin
			shift_q <= rx_byte;
			bit_q   <= bit_q + 4'h1;
		end
	end

	// target owns the ack slot only for bytes it accepted
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tgt_ack_q <= 1'b0;
		end else if (start_seen || state_d == ST_IDLE) begin
			tgt_ack_q <= 1'b0;
		end else if (byte_done) begin
			tgt_ack_q <= ack_due;
		end
	end

	// pointer survives across transactions
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ptr_q <= POINTER_RST;
		end else if (byte_done && state_q == ST_PTR) begin
			ptr_q <= rx_byte;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wr_hi_q <= 8'h00;
			wdata_q <= 16'h0000;
			we_q    <= 1'b0;
		end else begin
			we_q <= 1'b0;
			if (byte_done && state_q == ST_WHI) begin
				wr_hi_q <= rx_byte;
			end
			if (byte_done && state_q == ST_WLO) begin
				wdata_q <= {wr_hi_q, rx_byte};
				we_q    <= 1'b1;
			end
		end
	end

	// transmit byte: high byte loaded on the eighth address rise, before the ack slot; low byte after master ack
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tx_q    <= 8'h00;
			rd_lo_q <= 1'b0;
		end else if (byte_done && state_q == ST_ADDR) begin
			tx_q    <= reg_rdata[15:8];
			rd_lo_q <= 1'b0;
		end else if (master_ack_slot && scl_rise && !sda_level && !rd_lo_q) begin
			tx_q    <= reg_rdata[7:0];
			rd_lo_q <= 1'b1;
		end else if (in_read && !ack_phase_q && !byte_full && scl_fall) begin
			// ones fill past the low byte so the line is left released
			tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	// sda only changes while scl is low
	wire ack_drive = ack_phase_q && tgt_ack_q;
	wire tx_drive  = in_read && !ack_phase_q && !tx_q[7];

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			drive_q <= 1'b0;
		end else if (state_d == ST_IDLE || start_seen) begin
			drive_q <= 1'b0;
		end else if (!scl_level || scl_fall) begin
			drive_q <= ack_drive || tx_drive;
		end
	end

	// silence counter for the stalled-bus release
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			idle_cnt_q <= 32'h0000_0000;
			tout_q     <= 1'b0;
		end else begin
			tout_q <= tout_hit;
			if (!active || scl_rise || scl_fall) begin
				idle_cnt_q <= 32'h0000_0000;
			end else begin
				idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
			end
		end
	end

	assign sda_val     = 1'b0;
	assign sda_oe      = drive_q;
	assign reg_index   = ptr_q;
	assign reg_wdata   = wdata_q;
	assign reg_we      = we_q;
	assign bus_timeout = tout_q;

	a_write_pulse: assert property (@(posedge mclk) disable iff (reset)
		(byte_done && state_q == ST_WLO) |=> reg_we && reg_wdata[7:0] == $past(rx_byte))
		else $error("write strobe missing after low byte");
	a_ptr_load: assert property (@(posedge mclk) disable iff (reset)
		(byte_done && state_q == ST_PTR) |=> reg_index == $past(rx_byte))
		else $error("pointer not loaded");
	a_ptr_hold: assert property (@(posedge mclk) disable iff (reset)
		!(byte_done && state_q == ST_PTR) |=> $stable(reg_index))
		else $error("pointer changed without pointer byte");
	a_high_first: assert property (@(posedge mclk) disable iff (reset)
		(byte_done && state_q == ST_ADDR && addr_match && rd_sel) |=> tx_q == $past(reg_rdata[15:8]))
		else $error("high byte not loaded first");
	a_timeout_idle: assert property (@(posedge mclk) disable iff (reset)
		(tout_hit && !start_seen) |=> state_q == ST_IDLE && bus_timeout)
		else $error("timeout did not release");
	a_no_drive_idle: assert property (@(posedge mclk) disable iff (reset)
		(state_q == ST_IDLE) |=> !sda_oe)
		else $error("driving sda while idle");
	a_start_addr: assert property (@(posedge mclk) disable iff (reset)
		start_seen |=> state_q == ST_ADDR)
		else $error("repeated start not taken");
	a_miss_quiet: assert property (@(posedge mclk) disable iff (reset)
		(byte_done && state_q == ST_ADDR && !addr_match) |=> state_q == ST_DONE)
		else $error("foreign address accepted");
	a_ack_drive: assert property (@(posedge mclk) disable iff (reset)
		(ack_phase_q && tgt_ack_q && !start_seen && !stop_seen && !tout_hit) |=> sda_oe)
		else $error("accepted byte not acknowledged");
endmodule
`default_nettype wire

// file: bench/ts_master_model.sv
// two-wire bus master model for the register access target
`timescale 1ns/1ns
`default_nettype none
module ts_master_model (
	input  wire logic mclk,
	input  wire logic sda_seen,
	output var logic  scl,
	output var logic  sda
);
	// 52 mclk per bit, about 960 kHz
	localparam int Q = 13;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic wq();
		repeat (Q) @(posedge mclk);
	endtask
	// from idle or mid-frame; no stop needed before a repeated start
	task automatic start();
		sda <= 1'b1;
		wq();
		scl <= 1'b1;
		wq();
		sda <= 1'b0;
		wq();
		scl <= 1'b0;
		wq();
	endtask
	task automatic stop();
		sda <= 1'b0;
		wq();
		scl <= 1'b1;
		wq();
		sda <= 1'b1;
		wq();
	endtask
	task automatic bit1(input logic b, output logic r);
		sda <= b;
		wq();
		scl <= 1'b1;
		wq();
		r = sda_seen;
		wq();
		scl <= 1'b0;
		wq();
	endtask
	// msb first, ninth clock carries the acknowledge
	task automatic xfer(input logic [7:0] d, input logic ao, output logic [7:0] r,
		output logic ai);
		for (int i = 7; i >= 0; i--) begin
			bit1(d[i], r[i]);
		end
		bit1(ao, ai);
	endtask
endmodule
`default_nettype wire

// file: bench/ts_reg_access_tb_top.sv
// self-checking bench for the two-wire register access target
`timescale 1ns/1ns
`default_nettype none
module ts_reg_access_tb_top
	import ts_access_pkg::*;
();
	localparam int unsigned TO_CYC = 2000;
	logic mclk, reset, scl, sda_m, sda_oe, sda_o, reg_we, bus_timeout, ack;
	logic [7:0] reg_index, hi, lo;
	logic [15:0] reg_rdata, reg_wdata, last_w;
	logic [6:0] dev_addr;
	int error_cnt, tests_run, we_cnt;
	// pull-up wins unless the master or the target pulls low
	wire sda = sda_m & ~(sda_oe & ~sda_o);
	ts_reg_access #(.TIMEOUT_CYCLES(TO_CYC)) uut (.mclk(mclk), .reset(reset),
		.dev_addr(dev_addr), .scl(scl), .sda(sda), .sda_val(sda_o), .sda_oe(sda_oe),
		.reg_index(reg_index), .reg_rdata(reg_rdata), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .bus_timeout(bus_timeout));
	ts_master_model m (.mclk(mclk), .sda_seen(sda), .scl(scl), .sda(sda_m));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// register file stand-in: value derived from the index
	always @(posedge mclk) begin
		reg_rdata <= {reg_index, ~reg_index};
		if (reg_we === 1'b1) begin
			we_cnt <= we_cnt + 1;
			last_w <= reg_wdata;
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic wb(input logic [7:0] d, input logic exp);
		m.xfer(d, 1'b1, hi, ack);
		chk("ack", 16'(exp), 16'(ack));
	endtask
	task automatic rd(input logic [15:0] exp);
		m.xfer(8'hFF, 1'b0, hi, ack);
		m.xfer(8'hFF, 1'b1, lo, ack);
		m.stop();
		chk("word", exp, {hi, lo});
	endtask
	task automatic t_write();
		int n;
		n = we_cnt;
		m.start();
		wb({dev_addr, 1'b0}, 1'b0);
		wb(8'h5A, 1'b0);
		wb(8'hC3, 1'b0);
		chk("we_early", 16'(n), 16'(we_cnt));
		wb(8'h3C, 1'b0);
		wb(8'h99, 1'b1);
		m.stop();
		chk("we_cnt", 16'(n + 1), 16'(we_cnt));
		chk("wdata", 16'hC33C, last_w);
		chk("index", 16'h005A, 16'(reg_index));
		$display("write done");
	endtask
	task automatic t_reads();
		m.start();
		wb({dev_addr, 1'b0}, 1'b0);
		wb(8'h07, 1'b0);
		m.start();
		wb({dev_addr, 1'b1}, 1'b0);
		rd(16'h07F8);
		m.start();
		wb({dev_addr, 1'b1}, 1'b0);
		rd(16'h07F8);
		$display("reads done");
	endtask
	task automatic t_refuse();
		int n;
		n = we_cnt;
		m.start();
		wb({dev_addr ^ 7'h01, 1'b0}, 1'b1);
		wb(8'h33, 1'b1);
		m.stop();
		chk("index_kept", 16'h0007, 16'(reg_index));
		m.start();
		wb({dev_addr, 1'b0}, 1'b0);
		wb(8'h22, 1'b0);
		wb(8'h44, 1'b0);
		m.stop();
		chk("odd_byte", 16'(n), 16'(we_cnt));
		$display("refuse done");
	endtask
	task automatic t_timeout();
		int n;
		m.start();
		wb({dev_addr, 1'b1}, 1'b0);
		n = 0;
		while (bus_timeout !== 1'b1 && n < 3 * TO_CYC) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("to_seen", 16'h0001, 16'(n > TO_CYC - 100 && n < TO_CYC + 100));
		chk("oe_free", 16'h0000, 16'(sda_oe));
		m.stop();
		m.start();
		wb({dev_addr, 1'b1}, 1'b0);
		rd(16'h22DD);
		$display("timeout done");
	endtask
	initial begin
		reset = 1'b1;
		dev_addr = DEV_ADDR_RST;
		reg_rdata = 16'h0000;
		last_w = 16'h0000;
		we_cnt = 0;
		error_cnt = 0;
		tests_run = 0;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1 chk("rst_index", 16'(POINTER_RST), 16'(reg_index));
		chk("rst_oe", 16'h0000, 16'(sda_oe));
		t_write();
		t_reads();
		t_refuse();
		t_timeout();
		wrap_up();
	end
endmodule
`default_nettype wire
